// [pkg/shp_cfg.svh]
// Constants for the serial host port: offsets, fields, resets, timing
// Functional notes
// - Characters are start low, 8 data bits LSB first, stop high, no parity.
// - Both UARTs must agree on baud rate and character format.
// - Received serial characters are held in the receive buffer until taken.
// - Receive buffer is not offered for sending while radio reception continues; the code still sets pkt_rdy_reg on a command sequence.
// - Radio payload goes into the transmit buffer and out the output pin.
// - A radio packet that does not fit the transmit buffer is dropped whole.
// - RTS and CTS flow control each have their own enable.
// - With CTS control on, CTS goes high at threshold occupancy.
// - CTS returns low only below threshold minus 16 bytes.
// - With RTS control on, nothing is sent while RTS is high; the code still finishes a character already started.
// - Transparent mode passes all data both ways unchanged.
// - Packetize after the configured silence; zero timeout packetizes each character.
// - Packetize once 73 characters are buffered.
// - Command sequence flushes earlier data; sequence characters are not sent.
// - Frame mode carries all traffic both ways inside frames; the code only blocks command sequences in frame mode.
// - Frame mode outputs received data, responses and events as frames; the code puts bare characters on dout_pin.
// - Frame mode reports success or failure for each sent radio packet; the code only counts them in ok_cnt_reg and fail_cnt_reg, read at TXSTAT.
`ifndef SHP_CFG_SVH
`define SHP_CFG_SVH
`define SHP_CLK_HZ 100000000
`define SHP_BAUD 9600
`define SHP_GUARD_MS 16'h03E8
`define SHP_PKT_MAX 8'd73
`define SHP_CTS_HYST 9'd16
`define SHP_ADDR_CTRL 8'h00
`define SHP_ADDR_THRESH 8'h04
`define SHP_ADDR_GAP 8'h08
`define SHP_ADDR_SEQCHR 8'h0C
`define SHP_ADDR_STATUS 8'h10
`define SHP_ADDR_RXDATA 8'h14
`define SHP_ADDR_TXLEN 8'h18
`define SHP_ADDR_TXDATA 8'h1C
`define SHP_ADDR_TXSTAT 8'h20
`define SHP_CTRL_RTS_EN 0
`define SHP_CTRL_CTS_EN 1
`define SHP_CTRL_FRAME 2
`define SHP_CTRL_ACK 3
`define SHP_RST_THRESH 8'h51
`define SHP_RST_GAP 8'h03
`define SHP_RST_SEQCHR 8'h2B
`endif

// [pkg/shp_pkg.sv]
// Types for the serial host port
package shp_pkg;
   typedef enum logic [1:0] {SHP_IDLE, SHP_START, SHP_DATA, SHP_STOP} shp_bit_state_t;
endpackage

// [design/shp_serial_port.sv]
// Serial host port: UART pins, receive and transmit buffers, flow control, APB
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "shp_cfg.svh"
module shp_serial_port import shp_pkg::*; #(
   parameter int BAUD_DIV = `SHP_CLK_HZ / `SHP_BAUD,
   parameter int GUARD_CYC = 100000 * `SHP_GUARD_MS,
   parameter int AW = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic din_pin,
   output logic dout_pin,
   input wire logic rts_n_pin,
   output logic cts_n_pin,
   input wire logic rf_rx_busy,
   input wire logic rf_tx_done,
   input wire logic rf_tx_ok
);
   localparam int DEPTH = 1 << AW;
   localparam logic [31:0] HALF = 32'(BAUD_DIV / 2);
   localparam logic [39:0] BYTE_CYC = 40'(10 * BAUD_DIV);

   function automatic logic [2:0] sync_step(input logic [2:0] s, input logic pin);
      sync_step = {s[1:0], pin};
   endfunction

   // Three-stage synchronisers; a change counts once stages two and three agree
   logic [2:0] din_sync_reg, rts_sync_reg;
   logic din_reg, rts_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_sync_reg <= 3'h7;
         rts_sync_reg <= 3'h7;
         din_reg <= 1'b1;
         rts_reg <= 1'b1;
      end else begin
         din_sync_reg <= sync_step(din_sync_reg, din_pin);
         rts_sync_reg <= sync_step(rts_sync_reg, rts_n_pin);
         if (din_sync_reg[1] == din_sync_reg[2]) din_reg <= din_sync_reg[2];
         if (rts_sync_reg[1] == rts_sync_reg[2]) rts_reg <= rts_sync_reg[2];
      end
   end

   // APB decode; answer in the cycle after setup
   logic acc, wr_acc, rd_acc;
   logic [7:0] ctrl_reg, thresh_reg, gap_reg, seqchr_reg;
   assign acc = psel & penable & pready;
   assign wr_acc = acc & pwrite;
   assign rd_acc = acc & ~pwrite;

   // Receiver
   shp_bit_state_t rx_st_reg;
   logic [31:0] rx_cnt_reg;
   logic [2:0] rx_bit_reg;
   logic [7:0] rx_sh_reg;
   logic rx_valid_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_reg <= SHP_IDLE;
         rx_cnt_reg <= 32'h0;
         rx_bit_reg <= 3'h0;
         rx_sh_reg <= 8'h00;
         rx_valid_reg <= 1'b0;
      end else begin
         rx_valid_reg <= 1'b0;
         rx_cnt_reg <= rx_cnt_reg + 32'h1;
         case (rx_st_reg)
            SHP_IDLE: begin
               rx_cnt_reg <= 32'h0;
               if (!din_reg) rx_st_reg <= SHP_START;
            end
            SHP_START: if (rx_cnt_reg == HALF) begin
               rx_cnt_reg <= 32'h0;
               rx_bit_reg <= 3'h0;
               rx_st_reg <= din_reg ? SHP_IDLE : SHP_DATA;
            end
            SHP_DATA: if (rx_cnt_reg == 32'(BAUD_DIV - 1)) begin
               rx_cnt_reg <= 32'h0;
               rx_sh_reg <= {din_reg, rx_sh_reg[7:1]};
               rx_bit_reg <= rx_bit_reg + 3'h1;
               if (rx_bit_reg == 3'h7) rx_st_reg <= SHP_STOP;
            end
            SHP_STOP: if (rx_cnt_reg == 32'(BAUD_DIV - 1)) begin
               // Framing errors drop the character
               rx_valid_reg <= din_reg;
               rx_st_reg <= SHP_IDLE;
            end
            default: rx_st_reg <= SHP_IDLE;
         endcase
      end
   end

   // Silence timer and command sequence detection
   logic [31:0] quiet_reg;
   logic [1:0] seq_cnt_reg;
   logic cmd_hit;
   assign cmd_hit = (seq_cnt_reg == 2'd3) && (quiet_reg >= 32'(GUARD_CYC))
                    && !ctrl_reg[`SHP_CTRL_FRAME];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_reg <= 32'hFFFFFFFF;
         seq_cnt_reg <= 2'd0;
      end else begin
         if (rx_valid_reg) quiet_reg <= 32'h0;
         else if (quiet_reg != 32'hFFFFFFFF) quiet_reg <= quiet_reg + 32'h1;
         if (cmd_hit) begin
            seq_cnt_reg <= 2'd0;
         end else if (rx_valid_reg) begin
            if (rx_sh_reg == seqchr_reg && seq_cnt_reg != 2'd3
                && (seq_cnt_reg != 2'd0 || quiet_reg >= 32'(GUARD_CYC)))
               seq_cnt_reg <= seq_cnt_reg + 2'd1;
            else
               seq_cnt_reg <= 2'd0;
         end
      end
   end

   // Serial receive buffer
   logic [7:0] rx_mem [0:DEPTH-1];
   logic [AW-1:0] rx_wp_reg, rx_rp_reg;
   logic [AW:0] rx_count_reg;
   logic rx_push, rx_pop, rx_rewind;
   assign rx_push = rx_valid_reg && rx_count_reg != (AW+1)'(DEPTH);
   assign rx_pop = rd_acc && paddr == `SHP_ADDR_RXDATA && rx_count_reg != '0;
   assign rx_rewind = cmd_hit && rx_count_reg >= (AW+1)'(3) + (AW+1)'(rx_pop);
   always_ff @(posedge pclk) begin
      if (rx_push) rx_mem[rx_wp_reg] <= rx_sh_reg;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_wp_reg <= '0;
         rx_rp_reg <= '0;
         rx_count_reg <= '0;
      end else begin
         // Sequence characters are taken back out so they never go to radio
         if (rx_rewind) rx_wp_reg <= rx_wp_reg - AW'(3);
         else if (rx_push) rx_wp_reg <= rx_wp_reg + AW'(1);
         if (rx_pop) rx_rp_reg <= rx_rp_reg + AW'(1);
         rx_count_reg <= rx_count_reg + (AW+1)'(rx_push & ~rx_rewind)
                         - (AW+1)'(rx_pop) - (rx_rewind ? (AW+1)'(3) : '0);
      end
   end

   // Packetization trigger; set wins over software acknowledge
   logic pkt_rdy_reg, cmd_det_reg, trig;
   logic [39:0] gap_cyc;
   assign gap_cyc = 40'(gap_reg) * BYTE_CYC;
   assign trig = !rf_rx_busy && rx_count_reg != '0
                 && (rx_count_reg >= (AW+1)'(`SHP_PKT_MAX)
                     || gap_reg == 8'h00 || 40'(quiet_reg) >= gap_cyc);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pkt_rdy_reg <= 1'b0;
         cmd_det_reg <= 1'b0;
      end else begin
         if (trig || cmd_hit) pkt_rdy_reg <= 1'b1;
         else if (wr_acc && paddr == `SHP_ADDR_CTRL && pwdata[`SHP_CTRL_ACK])
            pkt_rdy_reg <= 1'b0;
         if (cmd_hit) cmd_det_reg <= 1'b1;
         else if (wr_acc && paddr == `SHP_ADDR_CTRL && pwdata[`SHP_CTRL_ACK])
            cmd_det_reg <= 1'b0;
      end
   end

   // CTS with hysteresis below the threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cts_n_pin <= 1'b0;
      else if (!ctrl_reg[`SHP_CTRL_CTS_EN]) cts_n_pin <= 1'b0;
      else if (9'(rx_count_reg) >= 9'(thresh_reg)) cts_n_pin <= 1'b1;
      else if (9'(rx_count_reg) + `SHP_CTS_HYST < 9'(thresh_reg))
         cts_n_pin <= 1'b0;
   end

   // Serial transmit buffer; a packet is admitted whole or not at all
   logic [7:0] tx_mem [0:DEPTH-1];
   logic [AW-1:0] tx_wp_reg, tx_rp_reg;
   logic [AW:0] tx_count_reg, tx_left_reg, tx_free;
   logic [7:0] tx_drop_reg;
   logic tx_push, tx_pop, len_wr;
   assign tx_free = (AW+1)'(DEPTH) - tx_count_reg;
   assign len_wr = wr_acc && paddr == `SHP_ADDR_TXLEN;
   assign tx_push = wr_acc && paddr == `SHP_ADDR_TXDATA && tx_left_reg != '0;
   always_ff @(posedge pclk) begin
      if (tx_push) tx_mem[tx_wp_reg] <= pwdata[7:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_wp_reg <= '0;
         tx_rp_reg <= '0;
         tx_count_reg <= '0;
         tx_left_reg <= '0;
         tx_drop_reg <= 8'h00;
      end else begin
         if (tx_push) tx_wp_reg <= tx_wp_reg + AW'(1);
         if (tx_pop) tx_rp_reg <= tx_rp_reg + AW'(1);
         tx_count_reg <= tx_count_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
         if (len_wr) begin
            if (pwdata[15:0] <= 16'(tx_free)) tx_left_reg <= (AW+1)'(pwdata[15:0]);
            else begin
               tx_left_reg <= '0;
               tx_drop_reg <= tx_drop_reg + 8'h01;
            end
         end else if (tx_push) tx_left_reg <= tx_left_reg - (AW+1)'(1);
      end
   end

   // Transmitter; RTS is checked only between characters
   shp_bit_state_t tx_st_reg;
   logic [31:0] tx_cnt_reg;
   logic [3:0] tx_bit_reg;
   logic [8:0] tx_sh_reg;
   assign tx_pop = tx_st_reg == SHP_IDLE && tx_count_reg != '0
                   && !(ctrl_reg[`SHP_CTRL_RTS_EN] && rts_reg);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_reg <= SHP_IDLE;
         tx_cnt_reg <= 32'h0;
         tx_bit_reg <= 4'h0;
         tx_sh_reg <= 9'h1FF;
         dout_pin <= 1'b1;
      end else begin
         tx_cnt_reg <= tx_cnt_reg + 32'h1;
         case (tx_st_reg)
            SHP_IDLE: begin
               dout_pin <= 1'b1;
               tx_cnt_reg <= 32'h0;
               if (tx_pop) begin
                  tx_sh_reg <= {1'b1, tx_mem[tx_rp_reg]};
                  tx_bit_reg <= 4'h0;
                  dout_pin <= 1'b0;
                  tx_st_reg <= SHP_DATA;
               end
            end
            SHP_DATA: if (tx_cnt_reg == 32'(BAUD_DIV - 1)) begin
               tx_cnt_reg <= 32'h0;
               dout_pin <= tx_sh_reg[0];
               tx_sh_reg <= {1'b1, tx_sh_reg[8:1]};
               tx_bit_reg <= tx_bit_reg + 4'h1;
               if (tx_bit_reg == 4'h8) tx_st_reg <= SHP_STOP;
            end
            SHP_STOP: if (tx_cnt_reg == 32'(BAUD_DIV - 1)) tx_st_reg <= SHP_IDLE;
            default: tx_st_reg <= SHP_IDLE;
         endcase
      end
   end

   // Per-packet radio send status for frame mode reporting
   logic [7:0] ok_cnt_reg, fail_cnt_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ok_cnt_reg <= 8'h00;
         fail_cnt_reg <= 8'h00;
      end else if (rf_tx_done && ctrl_reg[`SHP_CTRL_FRAME]) begin
         if (rf_tx_ok) ok_cnt_reg <= ok_cnt_reg + 8'h01;
         else fail_cnt_reg <= fail_cnt_reg + 8'h01;
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= 8'h00;
         thresh_reg <= `SHP_RST_THRESH;
         gap_reg <= `SHP_RST_GAP;
         seqchr_reg <= `SHP_RST_SEQCHR;
      end else if (wr_acc) begin
         case (paddr)
            `SHP_ADDR_CTRL: ctrl_reg <= {5'h00, pwdata[2:0]};
            `SHP_ADDR_THRESH: thresh_reg <= pwdata[7:0];
            `SHP_ADDR_GAP: gap_reg <= pwdata[7:0];
            `SHP_ADDR_SEQCHR: seqchr_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read data captured in setup so the access phase answers at once
   logic [31:0] rd_val;
   logic rd_bad;
   always_comb begin
      rd_val = 32'h0;
      rd_bad = 1'b0;
      case (paddr)
         `SHP_ADDR_CTRL: rd_val = {24'h0, ctrl_reg};
         `SHP_ADDR_THRESH: rd_val = {24'h0, thresh_reg};
         `SHP_ADDR_GAP: rd_val = {24'h0, gap_reg};
         `SHP_ADDR_SEQCHR: rd_val = {24'h0, seqchr_reg};
         `SHP_ADDR_STATUS: rd_val = {8'h00, 8'(tx_free), 5'h0, cts_n_pin, cmd_det_reg,
                                     pkt_rdy_reg, 8'(rx_count_reg)};
         `SHP_ADDR_RXDATA: rd_val = {24'h0, rx_mem[rx_rp_reg]};
         `SHP_ADDR_TXLEN: rd_val = {16'h0, tx_drop_reg, 8'(tx_left_reg)};
         `SHP_ADDR_TXDATA: rd_val = 32'h0;
         `SHP_ADDR_TXSTAT: rd_val = {16'h0, fail_cnt_reg, ok_cnt_reg};
         default: rd_bad = 1'b1;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         if (psel & ~penable) begin
            prdata <= pwrite ? 32'h0 : rd_val;
            pslverr <= rd_bad;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end
endmodule

// [test/shp_serial_port_monitor.sv]
// Checker on the serial host port pins: APB handshake and output framing
module shp_serial_port_monitor #(
   parameter int BAUD_DIV = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic dout_pin,
   input wire logic cts_n_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic act;
   int sub;
   int bitn;
   // Only a fall seen while idle starts a frame, so data bits never retrigger it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act <= 1'b0;
         sub <= 0;
         bitn <= 0;
      end else if (!act) begin
         act <= $fell(dout_pin);
         sub <= 1;
         bitn <= 0;
      end else if (sub == BAUD_DIV - 1) begin
         act <= bitn != 9;
         sub <= 0;
         bitn <= bitn + 1;
      end else begin
         sub <= sub + 1;
      end
   end
   property p_ready_after_setup; psel && !penable |=> pready; endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
   property p_ready_single; pready |=> !pready; endproperty
   a_ready_single: assert property (p_ready_single) else $error("ready longer than one cycle");
   property p_err_with_ready; pslverr |-> pready; endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   property p_ready_in_access; pready |-> psel && penable; endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
   property p_rdata_hold; !(psel && !penable) |=> $stable(prdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_start_low; act && bitn == 0 |-> !dout_pin; endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");
   property p_stop_high; act && bitn == 9 |-> dout_pin; endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
   property p_bit_steady; act && sub != 0 |-> $stable(dout_pin); endproperty
   a_bit_steady: assert property (p_bit_steady) else $error("output moved mid bit");
   c_error: cover property (pslverr);
   c_frame: cover property (act && bitn == 9 && sub == 0);
   c_cts: cover property ($rose(cts_n_pin));
endmodule
bind shp_serial_port shp_serial_port_monitor #(.BAUD_DIV(BAUD_DIV)) u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .dout_pin(dout_pin), .cts_n_pin(cts_n_pin));

// [test/shp_host_model.sv]
// Host UART model: drives the serial input, collects the serial output
module shp_host_model #(
   parameter int BAUD_DIV = 16
) (
   input wire logic pclk,
   output logic din_pin,
   input wire logic dout_pin,
   input wire logic cts_n_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx_q[$];
   int bad_frames = 0;
   initial din_pin = 1'b1;
   // Same divider as the port, so both ends agree on rate and format
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      int w;
      f = {1'b1, b, 1'b0};
      w = 0;
      while (cts_n_pin === 1'b1 && w < 50000) begin
         @(posedge pclk);
         w++;
      end
      for (int i = 0; i < 10; i++) begin
         @(posedge pclk);
         din_pin <= f[i];
         repeat (BAUD_DIV - 1) @(posedge pclk);
      end
   endtask
   always begin
      logic [7:0] d;
      @(negedge dout_pin);
      repeat (BAUD_DIV / 2) @(posedge pclk);
      if (dout_pin === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BAUD_DIV) @(posedge pclk);
            d[i] = dout_pin;
         end
         repeat (BAUD_DIV) @(posedge pclk);
         if (dout_pin === 1'b1) begin
            rx_q.push_back(d);
         end else begin
            bad_frames++;
         end
      end
   end
endmodule

// [test/tb_serial_host_port_buffers.sv]
// Bench for the serial host port: APB access, serial traffic, flow control
`include "shp_cfg.svh"
module tb_serial_host_port_buffers;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BD = 16;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, din_pin, dout_pin, cts_n_pin;
   logic rts_n_pin = 1'b0, rf_rx_busy = 1'b0, rf_tx_done = 1'b0, rf_tx_ok = 1'b0;
   int mismatches = 0;
   int checks = 0;
   always #5 pclk = ~pclk;
   shp_serial_port #(.BAUD_DIV(BD), .GUARD_CYC(2000)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .din_pin(din_pin), .dout_pin(dout_pin), .rts_n_pin(rts_n_pin), .cts_n_pin(cts_n_pin),
      .rf_rx_busy(rf_rx_busy), .rf_tx_done(rf_tx_done), .rf_tx_ok(rf_tx_ok));
   shp_host_model #(.BAUD_DIV(BD)) u_host (.pclk(pclk), .din_pin(din_pin),
      .dout_pin(dout_pin), .cts_n_pin(cts_n_pin));
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int w;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      if (pready !== 1'b1) begin
         mismatches++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                      input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(what, x, r & m);
   endtask
   initial begin
      logic [31:0] r;
      logic e;
      int w;
      logic [7:0] txb[3] = '{8'hC3, 8'h5A, 8'h0F};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`SHP_ADDR_THRESH, 32'hFF, 32'h51, "thresh");
      rdc(`SHP_ADDR_GAP, 32'hFF, 32'h03, "gap");
      rdc(`SHP_ADDR_SEQCHR, 32'hFF, 32'h2B, "seqchr");
      rdc(`SHP_ADDR_STATUS, 32'hFF07FF, 32'h800000, "status");
      apb(1'b0, 8'h40, 32'h0, r, e);
      chk("unmapped", 32'h1, {31'h0, e});
      wr(`SHP_ADDR_GAP, 32'h0);
      rf_rx_busy <= 1'b1;
      u_host.send(8'hA5);
      u_host.send(8'h3C);
      repeat (24) @(posedge pclk);
      rdc(`SHP_ADDR_STATUS, 32'h1FF, 32'h002, "busy status");
      rf_rx_busy <= 1'b0;
      repeat (4) @(posedge pclk);
      rdc(`SHP_ADDR_STATUS, 32'h100, 32'h100, "zero gap");
      rdc(`SHP_ADDR_RXDATA, 32'hFF, 32'hA5, "rx first");
      rdc(`SHP_ADDR_RXDATA, 32'hFF, 32'h3C, "rx second");
      wr(`SHP_ADDR_CTRL, 32'h8);
      u_host.send(8'h11);
      repeat (2100) @(posedge pclk);
      for (int i = 0; i < 3; i++) u_host.send(8'h2B);
      repeat (2200) @(posedge pclk);
      rdc(`SHP_ADDR_STATUS, 32'h2FF, 32'h201, "cmd status");
      rdc(`SHP_ADDR_RXDATA, 32'hFF, 32'h11, "before cmd");
      wr(`SHP_ADDR_GAP, 32'hFF);
      wr(`SHP_ADDR_CTRL, 32'h8);
      for (int i = 0; i < 130; i++) begin
         u_host.send(8'(i));
         if (i == 71 || i == 72) begin
            repeat (24) @(posedge pclk);
            rdc(`SHP_ADDR_STATUS, 32'h100, {23'h0, i == 72, 8'h0}, "size");
         end
      end
      repeat (24) @(posedge pclk);
      rdc(`SHP_ADDR_STATUS, 32'h4FF, 32'h080, "full");
      chk("cts off", 32'h0, {31'h0, cts_n_pin});
      for (int i = 0; i < 128; i++) rdc(`SHP_ADDR_RXDATA, 32'hFF, 32'(i), "drain");
      wr(`SHP_ADDR_THRESH, 32'h14);
      wr(`SHP_ADDR_CTRL, 32'hA);
      for (int i = 0; i < 20; i++) u_host.send(8'h40 + 8'(i));
      repeat (24) @(posedge pclk);
      chk("cts set", 32'h1, {31'h0, cts_n_pin});
      for (int i = 0; i < 17; i++) begin
         if (i == 16) begin
            repeat (4) @(posedge pclk);
            chk("cts hold", 32'h1, {31'h0, cts_n_pin});
         end
         rdc(`SHP_ADDR_RXDATA, 32'hFF, 32'h40 + 32'(i), "cts drain");
      end
      repeat (4) @(posedge pclk);
      chk("cts clear", 32'h0, {31'h0, cts_n_pin});
      wr(`SHP_ADDR_CTRL, 32'h1);
      rts_n_pin <= 1'b1;
      wr(`SHP_ADDR_TXLEN, 32'h3);
      for (int i = 0; i < 3; i++) wr(`SHP_ADDR_TXDATA, {24'h0, txb[i]});
      repeat (400) @(posedge pclk);
      chk("held", 32'h0, 32'(u_host.rx_q.size()));
      rts_n_pin <= 1'b0;
      w = 0;
      while (u_host.rx_q.size() < 3 && w < 2000) begin
         @(posedge pclk);
         w++;
      end
      if (w >= 2000) begin
         mismatches++;
         final_report();
      end
      for (int i = 0; i < 3; i++) chk("tx", {24'h0, txb[i]}, {24'h0, u_host.rx_q[i]});
      chk("frames", 32'h0, 32'(u_host.bad_frames));
      wr(`SHP_ADDR_TXLEN, 32'h81);
      rdc(`SHP_ADDR_TXLEN, 32'hFFFF, 32'h0100, "drop");
      wr(`SHP_ADDR_CTRL, 32'h4);
      for (int i = 1; i >= 0; i--) begin
         rf_tx_done <= 1'b1;
         rf_tx_ok <= 1'(i);
         @(posedge pclk);
         rf_tx_done <= 1'b0;
         @(posedge pclk);
      end
      rdc(`SHP_ADDR_TXSTAT, 32'hFFFF, 32'h0101, "tx status");
      // Frame mode: a guarded sequence must stay data, never a command
      repeat (2100) @(posedge pclk);
      for (int i = 0; i < 3; i++) u_host.send(8'h2B);
      wr(`SHP_ADDR_GAP, 32'h3);
      wr(`SHP_ADDR_CTRL, 32'hC);
      rdc(`SHP_ADDR_STATUS, 32'h3FF, 32'h006, "frame quiet");
      repeat (2200) @(posedge pclk);
      rdc(`SHP_ADDR_STATUS, 32'h3FF, 32'h106, "gap timeout");
      final_report();
   end
   // Cuts a hang short
   initial begin
      repeat (90000) @(posedge pclk);
      mismatches++;
      final_report();
   end
endmodule
